// >>> src/tcwb_bank.sv
// Purpose: Transceiver control word bank, mode entry and control decode
// Assumes: Pins asynchronous to clk_in; serial word quiet while strobe high
// Notes:   Shared pin is low select pin in pin mode, load strobe afterwards

`timescale 1ns/1ps

module tcwb_bank #(
    parameter int WORD_W    = tcwb_pkg::WORD_W,
    parameter int NUM_WORDS = tcwb_pkg::NUM_WORDS
) (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              ce_in,
    input  wire logic              serial_clk_in,
    input  wire logic              serial_input_line_in,
    input  wire logic              serial_load_strobe_in,
    input  wire logic              freq_select_high_pin_in,
    input  wire logic              synth_lock_in,
    input  wire logic              gain_pin_in,
    input  wire logic              keying_pin_in,
    input  wire logic              data_pin_in,
    output logic                   lock_indicator_out,
    output logic                   lock_indicator_oe_out,
    output logic                   programmable_mode_out,
    output logic      [WORD_W-1:0] op_word_out,
    output logic      [WORD_W-1:0] osc_word_out,
    output logic      [WORD_W-1:0] rxd_word_out,
    output logic      [WORD_W-1:0] txd_word_out,
    output logic      [1:0]        operating_mode_out,
    output logic                   pa_enable_out,
    output logic                   amp_gain_high_out,
    output logic                   fsk_select_out,
    output logic                   tx_data_out,
    output logic                   ref_osc_run_out,
    output logic                   synth_run_out
);

    // ==========================================================
    // Serial shifter on the link clock
    // ==========================================================
    logic [WORD_W-1:0] shift_word;

    tcwb_shifter #(
        .WORD_W (WORD_W)
    ) u_shifter (
        .serial_clk_in        (serial_clk_in),
        .serial_input_line_in (serial_input_line_in),
        .shift_word_out       (shift_word)
    );

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    localparam int NSYNC = 6;
    localparam int S_STB = 0;
    localparam int S_FSH = 1;
    localparam int S_LCK = 2;
    localparam int S_GAN = 3;
    localparam int S_KEY = 4;
    localparam int S_DAT = 5;

    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] meta_r;
    logic [NSYNC-1:0] sync_r;

    assign pin_raw = {data_pin_in, keying_pin_in, gain_pin_in, synth_lock_in,
                      freq_select_high_pin_in, serial_load_strobe_in};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk_in) begin
                if (!rst_n_in) begin
                    meta_r[gi] <= 1'b0;
                    sync_r[gi] <= 1'b0;
                end else if (ce_in) begin
                    meta_r[gi] <= pin_raw[gi];
                    sync_r[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Mode entry
    // ==========================================================
    tcwb_pkg::tcwb_state_t state_r;
    logic [tcwb_pkg::SETTLE_W-1:0] settle_r;
    logic [1:0] pins_r;
    logic       strobe_prev_r;
    logic       load_pulse;

    assign load_pulse = (state_r == tcwb_pkg::TCWB_PROG) && sync_r[S_STB] && !strobe_prev_r;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            strobe_prev_r <= 1'b0;
        end else if (ce_in) begin
            strobe_prev_r <= sync_r[S_STB];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_r  <= tcwb_pkg::TCWB_INIT;
            settle_r <= '0;
            pins_r   <= 2'h0;
        end else if (ce_in) begin
            unique case (state_r)
                tcwb_pkg::TCWB_INIT: begin
                    settle_r <= settle_r + 1'b1;
                    if (settle_r == tcwb_pkg::SETTLE_CYC) begin
                        pins_r  <= {sync_r[S_FSH], sync_r[S_STB]};
                        state_r <= tcwb_pkg::TCWB_PIN;
                    end
                end
                tcwb_pkg::TCWB_PIN: begin
                    if (sync_r[S_STB] != pins_r[0]) begin
                        state_r <= tcwb_pkg::TCWB_PROG;
                    end
                end
                tcwb_pkg::TCWB_PROG: begin
                    state_r <= tcwb_pkg::TCWB_PROG;
                end
                default: begin
                    state_r <= tcwb_pkg::TCWB_INIT;
                end
            endcase
        end
    end

    // ==========================================================
    // Word latches
    // ==========================================================
    logic [WORD_W-1:0] word_r [NUM_WORDS];
    logic [1:0]        load_addr;

    assign load_addr = shift_word[WORD_W-1 -: 2];

    generate
        for (gi = 0; gi < NUM_WORDS; gi++) begin : g_word
            always_ff @(posedge clk_in) begin
                if (!rst_n_in) begin
                    word_r[gi] <= tcwb_pkg::default_word(2'(gi), 2'h0);
                end else if (ce_in) begin
                    if (state_r != tcwb_pkg::TCWB_PROG) begin
                        word_r[gi] <= tcwb_pkg::default_word(2'(gi), pins_r);
                    end else if (load_pulse && load_addr == 2'(gi)) begin
                        word_r[gi] <= shift_word;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Field decode
    // ==========================================================
    tcwb_pkg::tcwb_op_word_t  op_w;
    tcwb_pkg::tcwb_rxd_word_t rxd_w;
    tcwb_pkg::tcwb_txd_word_t txd_w;
    logic lock_seen_r;
    logic lock_state;
    logic prog_mode;

    assign op_w      = tcwb_pkg::tcwb_op_word_t'(word_r[tcwb_pkg::ADDR_OP]);
    assign rxd_w     = tcwb_pkg::tcwb_rxd_word_t'(word_r[tcwb_pkg::ADDR_RXD]);
    assign txd_w     = tcwb_pkg::tcwb_txd_word_t'(word_r[tcwb_pkg::ADDR_TXD]);
    assign prog_mode = (state_r == tcwb_pkg::TCWB_PROG);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            lock_seen_r <= 1'b0;
        end else if (ce_in) begin
            if (sync_r[S_LCK]) begin
                lock_seen_r <= 1'b1;
            end else if (load_pulse && load_addr == tcwb_pkg::ADDR_OP) begin
                lock_seen_r <= 1'b0;
            end
        end
    end

    assign lock_state = op_w.lock_observation_select ? sync_r[S_LCK]
                                                      : (lock_seen_r || sync_r[S_LCK]);

    // ==========================================================
    // Registered outputs
    // ==========================================================
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            op_word_out           <= '0;
            osc_word_out          <= '0;
            rxd_word_out          <= '0;
            txd_word_out          <= '0;
            programmable_mode_out <= 1'b0;
            lock_indicator_out    <= 1'b0;
            lock_indicator_oe_out <= 1'b0;
        end else if (ce_in) begin
            op_word_out           <= word_r[tcwb_pkg::ADDR_OP];
            osc_word_out          <= word_r[tcwb_pkg::ADDR_OSC];
            rxd_word_out          <= word_r[tcwb_pkg::ADDR_RXD];
            txd_word_out          <= word_r[tcwb_pkg::ADDR_TXD];
            programmable_mode_out <= prog_mode;
            // Shared pin drives lock only once programmable
            lock_indicator_out    <= prog_mode && lock_state;
            lock_indicator_oe_out <= prog_mode;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            operating_mode_out <= tcwb_pkg::TCWB_STANDBY;
            pa_enable_out      <= 1'b0;
            ref_osc_run_out    <= 1'b0;
            synth_run_out      <= 1'b0;
        end else if (ce_in) begin
            operating_mode_out <= op_w.operating_mode_field;
            pa_enable_out      <= (op_w.operating_mode_field == tcwb_pkg::TCWB_TRANSMIT)
                                  && (op_w.power_amp_turn_on_rule || lock_state);
            ref_osc_run_out    <= (op_w.operating_mode_field != tcwb_pkg::TCWB_STANDBY);
            unique case (op_w.operating_mode_field)
                tcwb_pkg::TCWB_STANDBY:  synth_run_out <= 1'b0;
                tcwb_pkg::TCWB_RECEIVE:  synth_run_out <= 1'b1;
                tcwb_pkg::TCWB_TRANSMIT: synth_run_out <= 1'b1;
                tcwb_pkg::TCWB_IDLE:     synth_run_out <= op_w.idle_scope_bit;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            amp_gain_high_out <= 1'b1;
            fsk_select_out    <= 1'b0;
            tx_data_out       <= 1'b0;
        end else if (ce_in) begin
            amp_gain_high_out <= (rxd_w.amp_gain_source_bit == tcwb_pkg::SRC_INTERNAL)
                                 ? op_w.low_noise_amp_gain_bit : !sync_r[S_GAN];
            fsk_select_out    <= (txd_w.keying_source_select == tcwb_pkg::SRC_INTERNAL)
                                 ? op_w.keying_select : sync_r[S_KEY];
            tx_data_out       <= sync_r[S_DAT] ^ op_w.input_polarity_bit;
        end
    end

endmodule // tcwb_bank

// >>> src/tcwb_pkg.sv
// Contract
// - Four 24-bit words; bits 23:22 select operating, oscillator, receive, transmit word.
// - Pin-configured mode takes all words from defaults chosen by two select pins.
// - Programmable mode keeps pin-chosen defaults sampled before entry; host may rewrite.
// - Pins 00 and 01 give their band, bias, reference and feedback divider defaults.
// - Pins 10 and 11 give their band, bias, reference and feedback divider defaults.
// - Operating bits 9:0 hold receive reference ratio; host programs 4 to 1023.
// - Operating bits 11:10: standby 00 default, receive 01, transmit 10, idle 11.
// - Bit 12 gain low/high, effective only when receive word bit 21 selects internal.
// - Bit 16: 0 amplifier on after lock, 1 amplifier on throughout transmit.
// - Bit 17: 0 lock checked once then held high, 1 lock followed continuously.
// - Bit 18 selects lower charge-pump current at 0, higher at 1.
// - Bit 19 amplitude/frequency keying, effective only when transmit word bit 21 internal.
// - Bit 20 at 1 inverts the data input to keying mapping.
// - Bit 21: idle runs only reference oscillator at 0, whole synthesizer at 1.
// - Oscillator word field layout, with the host writing 1 to bit 20.
// - Receive word: gain source, detector polarity, bias, band, feedback ratio 16:0.
// - Each rising serial clock shifts data into 24-bit register, most significant first.
// - Rising load strobe copies shift register into the addressed word.
// - Extra leading bits are dropped; only the last 24 bits are kept.
// - First transition on the shared select/strobe pin enters programmable mode for good.
//
// Purpose: Constants, word layouts and defaults of the control word bank
// Assumes: Word index equals the two address bits
// Notes:   Defaults indexed by {high select pin, low select pin}

package tcwb_pkg;

    localparam int WORD_W    = 24;
    localparam int NUM_WORDS = 4;
    localparam int SETTLE_W  = 2;
    localparam logic [SETTLE_W-1:0] SETTLE_CYC = 2'h3;

    localparam logic [1:0] ADDR_OP  = 2'h0;
    localparam logic [1:0] ADDR_OSC = 2'h1;
    localparam logic [1:0] ADDR_RXD = 2'h2;
    localparam logic [1:0] ADDR_TXD = 2'h3;

    localparam logic SRC_INTERNAL = 1'b1;

    // Fixed default upper fields of each word
    localparam logic [11:0] OP_FIXED  = 12'h07c;
    localparam logic [11:0] OSC_FIXED = 12'h73a;
    localparam logic [1:0]  RXD_FIXED = 2'h0;
    localparam logic [4:0]  TXD_FIXED = 5'h04;

    typedef enum logic [1:0] {
        TCWB_STANDBY = 2'b00,
        TCWB_RECEIVE = 2'b01,
        TCWB_TRANSMIT = 2'b10,
        TCWB_IDLE    = 2'b11
    } tcwb_operating_mode_field_t;

    typedef enum logic [1:0] {
        TCWB_INIT = 2'b00,
        TCWB_PIN  = 2'b01,
        TCWB_PROG = 2'b10
    } tcwb_state_t;

    typedef struct packed {
        logic [1:0]   addr;
        logic         idle_scope_bit;
        logic         input_polarity_bit;
        logic         keying_select;
        logic         charge_pump_current_bit;
        logic         lock_observation_select;
        logic         power_amp_turn_on_rule;
        logic [1:0]   output_power_step;
        logic         set_one;
        logic         low_noise_amp_gain_bit;
        tcwb_operating_mode_field_t operating_mode_field;
        logic [9:0]   receive_reference_divider;
    } tcwb_op_word_t;

    typedef struct packed {
        logic [1:0] addr;
        logic       peak_detector_enable;
        logic       set_one;
        logic       delayed_synth_start;
        logic       gain_pin_hysteresis;
        logic       freq_control;
        logic       second_amplifier_enable;
        logic [2:0] oscillator_startup_current;
        logic [2:0] oscillator_steady_current;
        logic [9:0] transmit_reference_divider;
    } tcwb_osc_word_t;

    typedef struct packed {
        logic [1:0]  addr;
        logic        amp_gain_source_bit;
        logic        phase_detector_polarity;
        logic [1:0]  vco_bias_current;
        logic        band_select_bit;
        logic [16:0] receive_feedback_divider;
    } tcwb_rxd_word_t;

    typedef struct packed {
        logic [1:0]  addr;
        logic        keying_source_select;
        logic [1:0]  lock_detect_timing;
        logic [1:0]  error_timing_field;
        logic [16:0] transmit_feedback_divider;
    } tcwb_txd_word_t;

    // Per-pin default fields
    typedef struct packed {
        logic        band;
        logic [1:0]  vco;
        logic [9:0]  ref_div;
        logic [16:0] rx_fb;
        logic [16:0] tx_fb;
    } tcwb_pin_dflt_t;

    localparam tcwb_pin_dflt_t DFLT_00 = '{1'b1, 2'h3, 10'h010, 17'h0077f, 17'h00797};
    localparam tcwb_pin_dflt_t DFLT_01 = '{1'b0, 2'h1, 10'h020, 17'h00766, 17'h00796};
    localparam tcwb_pin_dflt_t DFLT_10 = '{1'b1, 2'h3, 10'h020, 17'h00fcf, 17'h00fff};
    localparam tcwb_pin_dflt_t DFLT_11 = '{1'b0, 2'h0, 10'h012, 17'h002fe, 17'h00319};

    // default word for an address and pin pair
    function automatic logic [WORD_W-1:0] default_word(input logic [1:0] addr,
                                                       input logic [1:0] pins);
        tcwb_pin_dflt_t d;
        logic [WORD_W-1:0] w;
        unique case (pins)
            2'h0: d = DFLT_00;
            2'h1: d = DFLT_01;
            2'h2: d = DFLT_10;
            2'h3: d = DFLT_11;
        endcase
        unique case (addr)
            ADDR_OP:  w = {addr, OP_FIXED, d.ref_div};
            ADDR_OSC: w = {addr, OSC_FIXED, d.ref_div};
            ADDR_RXD: w = {addr, RXD_FIXED, d.vco, d.band, d.rx_fb};
            ADDR_TXD: w = {addr, TXD_FIXED, d.tx_fb};
        endcase
        return w;
    endfunction

endpackage

// >>> src/tcwb_shifter.sv
// Purpose: Serial shift register on the serial clock
// Assumes: Serial clock stands still while the load strobe is high
// Notes:   No reset; content is data only

`timescale 1ns/1ps

module tcwb_shifter #(
    parameter int WORD_W = tcwb_pkg::WORD_W
) (
    input  wire logic              serial_clk_in,
    input  wire logic              serial_input_line_in,
    output logic      [WORD_W-1:0] shift_word_out
);

    logic [WORD_W-1:0] shift_r;

    always_ff @(posedge serial_clk_in) begin
        shift_r <= {shift_r[WORD_W-2:0], serial_input_line_in};
    end

    assign shift_word_out = shift_r;

endmodule // tcwb_shifter

// >>> verification/tb_top.sv
// Purpose: Self-checking bench of the control word bank
// Assumes: Host model owns the serial pins
// Notes:   Expected words kept in a local model
`timescale 1ns/1ps

module tb_top;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        hi_drv = 1'b0;
    logic        lock = 1'b0;
    logic        gpin = 1'b0;
    logic        kpin = 1'b0;
    logic        dpin = 1'b0;
    logic        sclk, sdat, stb, ld, oe, prog, pa, ghi, fsk, txo, rrun, srun;
    logic [1:0]  mode;
    logic [23:0] w_op, w_osc, w_rxd, w_txd;
    logic [23:0] m [4];
    wire         hi_wire = oe ? ld : hi_drv;
    int          n_fail = 0;
    int          comparisons = 0;

    always #2 clk_in = ~clk_in;

    tcwb_host_model host (.serial_clk_out(sclk), .serial_data_out(sdat), .strobe_out(stb));

    tcwb_bank uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .serial_clk_in(sclk),
        .serial_input_line_in(sdat), .serial_load_strobe_in(stb),
        .freq_select_high_pin_in(hi_wire), .synth_lock_in(lock), .gain_pin_in(gpin),
        .keying_pin_in(kpin), .data_pin_in(dpin), .lock_indicator_out(ld),
        .lock_indicator_oe_out(oe), .programmable_mode_out(prog), .op_word_out(w_op),
        .osc_word_out(w_osc), .rxd_word_out(w_rxd), .txd_word_out(w_txd),
        .operating_mode_out(mode), .pa_enable_out(pa), .amp_gain_high_out(ghi),
        .fsk_select_out(fsk), .tx_data_out(txo), .ref_osc_run_out(rrun), .synth_run_out(srun));

    // ========================================
    // Helpers
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [23:0] z(input logic v);
        return {23'h0, v};
    endfunction

    task automatic finish_test();
        if (n_fail == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic load(input logic [23:0] w);
        @(posedge clk_in);
        host.send(w);
        m[w[23:22]] = w;
        cyc(2);
        check(w_op, m[0]);
        check(w_osc, m[1]);
        check(w_rxd, m[2]);
        check(w_txd, m[3]);
    endtask

    // ========================================
    // Scenarios
    task automatic t_pins(input logic [1:0] p);
        logic [9:0]  r;
        logic [2:0]  vb;
        logic [16:0] nr;
        logic [16:0] nt;
        case (p)
            2'h0: {vb, r, nr, nt} = {3'h7, 10'h010, 17'h0077f, 17'h00797};
            2'h1: {vb, r, nr, nt} = {3'h2, 10'h020, 17'h00766, 17'h00796};
            2'h2: {vb, r, nr, nt} = {3'h7, 10'h020, 17'h00fcf, 17'h00fff};
            default: {vb, r, nr, nt} = {3'h0, 10'h012, 17'h002fe, 17'h00319};
        endcase
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        hi_drv <= p[1];
        host.set_pin(p[0]);
        cyc(20);
        rst_n_in <= 1'b1;
        cyc(12);
        m = '{{2'h0, 12'h07c, r}, {2'h1, 12'h73a, r}, {2'h2, 2'h0, vb, nr}, {2'h3, 5'h04, nt}};
        check(w_op, m[0]);
        check(w_osc, m[1]);
        check(w_rxd, m[2]);
        check(w_txd, m[3]);
        check(z(prog), 24'h000000);
        check(z(oe), 24'h000000);
    endtask

    task automatic t_enter();
        @(posedge clk_in);
        host.set_pin(1'b1);
        cyc(8);
        check(z(prog), 24'h000001);
        check(z(oe), 24'h000001);
        host.set_pin(1'b0);
        hi_drv <= 1'b1;
        cyc(8);
        check(z(prog), 24'h000001);
        check(w_op, m[0]);
        check(w_rxd, m[2]);
    endtask

    task automatic t_words();
        load(24'h05b004);
        load(24'h7fffff);
        load(24'ha15555);
        load(24'he2aaaa);
        host.lead(6'h3f);
        load(24'h05b3ff);
    endtask

    task automatic t_decode();
        logic [1:0] md;
        logic       sc;
        for (int i = 0; i < 8; i++) begin
            md = i[1:0];
            sc = i[2];
            load({2'h0, sc, 5'h01, 4'hf, md, 10'h010});
            check({22'h0, mode}, {22'h0, md});
            check(z(rrun), z(md != 2'h0));
            check(z(srun), z(md == 2'h1 || md == 2'h2 || (md == 2'h3 && sc)));
            check(z(pa), z(md == 2'h2));
        end
    endtask

    task automatic t_lock();
        logic [5:0] lp;
        logic [5:0] le;
        lp = 6'h12;
        le = 6'h16;
        load({2'h0, 6'h00, 4'hf, 2'h2, 10'h010});
        for (int i = 0; i < 6; i++) begin
            if (i == 3) load({2'h0, 6'h02, 4'hf, 2'h2, 10'h010});
            @(posedge clk_in);
            lock <= lp[i];
            cyc(6);
            check(z(pa), z(le[i]));
            check(z(ld), z(le[i]));
        end
    endtask

    task automatic t_select();
        logic [3:0] b;
        for (int i = 0; i < 16; i++) begin
            b = i[3:0];
            load({2'h2, b[3], 21'h015555});
            load({2'h3, b[3], 21'h02aaaa});
            load({2'h0, 1'b0, b[2], b[1], 3'h1, 2'h3, 1'b1, b[0], 2'h0, 10'h010});
            @(posedge clk_in);
            gpin <= b[0];
            kpin <= ~b[1];
            dpin <= b[3] ^ b[0];
            cyc(6);
            check(z(ghi), z(b[3] ? b[0] : ~b[0]));
            check(z(fsk), z(b[3] ? b[1] : ~b[1]));
            check(z(txo), z(b[3] ^ b[0] ^ b[2]));
        end
    endtask

    // ========================================
    // Watchdog and main sequence
    initial begin
        #100000;
        n_fail++;
        finish_test();
    end

    initial begin
        t_pins(2'h1);
        t_pins(2'h2);
        t_pins(2'h3);
        t_pins(2'h0);
        t_enter();
        t_words();
        t_decode();
        t_lock();
        t_select();
        finish_test();
    end
endmodule // tb_top

// >>> verification/tcwb_bank_assertions.sv
// Purpose: Port-level checks of the control word bank
// Assumes: Decoded outputs move together with the word outputs
// Notes:   Bound to every bank instance
`timescale 1ns/1ps

module tcwb_bank_assertions #(
    parameter int WORD_W = tcwb_pkg::WORD_W
) (
    input wire logic              clk_in,
    input wire logic              rst_n_in,
    input wire logic              serial_load_strobe_in,
    input wire logic              lock_indicator_out,
    input wire logic              lock_indicator_oe_out,
    input wire logic              programmable_mode_out,
    input wire logic [WORD_W-1:0] op_word_out,
    input wire logic [WORD_W-1:0] osc_word_out,
    input wire logic [WORD_W-1:0] rxd_word_out,
    input wire logic [WORD_W-1:0] txd_word_out,
    input wire logic [1:0]        operating_mode_out,
    input wire logic              pa_enable_out,
    input wire logic              amp_gain_high_out,
    input wire logic              fsk_select_out,
    input wire logic              ref_osc_run_out,
    input wire logic              synth_run_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // ========================================
    // Mode entry and word addressing
    chk_mode_sticky: assert property (programmable_mode_out |=> programmable_mode_out)
        else $error("Programmable mode dropped");
    chk_oe_prog: assert property (lock_indicator_oe_out |-> programmable_mode_out)
        else $error("Lock pin driven in pin mode");
    chk_word_addr: assert property (op_word_out[23:22] == 2'h0
        && (|osc_word_out -> osc_word_out[23:22] == 2'h1)
        && (|rxd_word_out -> rxd_word_out[23:22] == 2'h2)
        && (|txd_word_out -> txd_word_out[23:22] == 2'h3))
        else $error("Word address bits wrong");
    chk_words_quiet: assert property (
        (programmable_mode_out && !serial_load_strobe_in) [*6]
        |-> $stable({op_word_out, osc_word_out, rxd_word_out, txd_word_out}))
        else $error("Word changed without a load");

    // ========================================
    // Decoded controls
    chk_mode_field: assert property (operating_mode_out == op_word_out[11:10])
        else $error("Operating mode differs from word");
    chk_ref_run: assert property (ref_osc_run_out == (operating_mode_out != 2'h0))
        else $error("Reference run wrong");
    chk_synth_run: assert property (synth_run_out ==
        (operating_mode_out inside {2'h1, 2'h2} || (operating_mode_out == 2'h3 && op_word_out[21])))
        else $error("Synthesizer run wrong");
    chk_pa_mode: assert property (pa_enable_out |-> operating_mode_out == 2'h2)
        else $error("Amplifier on outside transmit");
    chk_pa_rule: assert property (operating_mode_out == 2'h2 && op_word_out[16] |-> pa_enable_out)
        else $error("Amplifier off in transmit");
    chk_gain_int: assert property (rxd_word_out[21] |-> amp_gain_high_out == op_word_out[12])
        else $error("Internal gain not followed");
    chk_key_int: assert property (txd_word_out[21] |-> fsk_select_out == op_word_out[19])
        else $error("Internal keying not followed");
    chk_lock_hold: assert property (
        programmable_mode_out && !op_word_out[17] && lock_indicator_out
        ##1 $stable(op_word_out) |-> lock_indicator_out)
        else $error("Held lock indicator fell");

    cover property ($rose(programmable_mode_out));
    cover property (pa_enable_out && !op_word_out[16]);
    cover property (synth_run_out && operating_mode_out == 2'h3);
endmodule // tcwb_bank_assertions

bind tcwb_bank tcwb_bank_assertions #(.WORD_W(WORD_W)) u_chk (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .serial_load_strobe_in(serial_load_strobe_in),
    .lock_indicator_out(lock_indicator_out), .lock_indicator_oe_out(lock_indicator_oe_out),
    .programmable_mode_out(programmable_mode_out), .op_word_out(op_word_out),
    .osc_word_out(osc_word_out), .rxd_word_out(rxd_word_out), .txd_word_out(txd_word_out),
    .operating_mode_out(operating_mode_out), .pa_enable_out(pa_enable_out),
    .amp_gain_high_out(amp_gain_high_out), .fsk_select_out(fsk_select_out),
    .ref_osc_run_out(ref_osc_run_out), .synth_run_out(synth_run_out));

// >>> verification/tcwb_host_model.sv
// Purpose: Host driving the three-wire configuration port
// Assumes: Serial clock 6 ns, still and low between frames
// Notes:   Released data line shows the inverse of its last bit
`timescale 1ns/1ps

module tcwb_host_model (
    output logic serial_clk_out,
    output logic serial_data_out,
    output logic strobe_out
);
    initial begin
        serial_clk_out = 1'b0;
        serial_data_out = 1'b0;
        strobe_out = 1'b0;
    end

    task automatic shift(input logic b);
        serial_data_out = b;
        #3 serial_clk_out = 1'b1;
        #3 serial_clk_out = 1'b0;
    endtask

    task automatic set_pin(input logic b);
        strobe_out <= b;
    endtask

    task automatic lead(input logic [5:0] v);
        #1.3;
        for (int i = 5; i >= 0; i--) shift(v[i]);
        serial_data_out = ~v[0];
    endtask

    // word sent as given, then held strobe
    task automatic send(input logic [23:0] w);
        #1.3;
        for (int i = 23; i >= 0; i--) shift(w[i]);
        serial_data_out = ~w[0];
        #3 strobe_out = 1'b1;
        #40 strobe_out = 1'b0;
        #20;
    endtask
endmodule // tcwb_host_model
